//--- rtl/fsel_pkg.sv
// Constants, field positions and carrier types of the floating-point
// status and exception logic.
// Assumes one core clock; all users reach the names as fsel_pkg::name.
package fsel_pkg;

  // Bit numbers count from the most significant end; P_ names are the
  // vector positions, which count from bit 0 at the least significant end.
  localparam int TOP = 31;
  localparam int P_FX = TOP - 0;
  localparam int P_FEX = TOP - 1;
  localparam int P_VX = TOP - 2;
  localparam int P_OX = TOP - 3;
  localparam int P_UX = TOP - 4;
  localparam int P_ZX = TOP - 5;
  localparam int P_XX = TOP - 6;
  localparam int P_SNAN = TOP - 7;
  localparam int P_ISI = TOP - 8;
  localparam int P_IDI = TOP - 9;
  localparam int P_ZDZ = TOP - 10;
  localparam int P_IMZ = TOP - 11;
  localparam int P_VC = TOP - 12;
  localparam int P_FR = TOP - 13;
  localparam int P_FI = TOP - 14;
  localparam int P_CLASS_HI = TOP - 15;
  localparam int P_CLASS_LO = TOP - 19;
  localparam int P_RSVD = TOP - 20;
  localparam int P_SOFT = TOP - 21;
  localparam int P_SQRT = TOP - 22;
  localparam int P_CVI = TOP - 23;
  localparam int P_VE = TOP - 24;
  localparam int P_OE = TOP - 25;
  localparam int P_UE = TOP - 26;
  localparam int P_ZE = TOP - 27;
  localparam int P_XE = TOP - 28;
  localparam int P_NI = TOP - 29;
  localparam int P_RND_HI = TOP - 30;
  localparam int P_RND_LO = TOP - 31;

  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  // Invalid-operation category bits and all sticky exception bits.
  localparam logic [31:0] INV_MASK = 32'h01F8_0700;
  localparam logic [31:0] EXC_MASK = 32'h1FF8_0700;

  localparam logic [1:0] RND_NEAREST = 2'h0;
  localparam logic [1:0] RND_ZERO = 2'h1;
  localparam logic [1:0] RND_PLUS_INF = 2'h2;
  localparam logic [1:0] RND_MINUS_INF = 2'h3;

  localparam logic [4:0] CLS_QNAN = 5'h11;
  localparam logic [4:0] CLS_NEG_INF = 5'h09;
  localparam logic [4:0] CLS_NEG_NORM = 5'h08;
  localparam logic [4:0] CLS_NEG_DENORM = 5'h18;
  localparam logic [4:0] CLS_NEG_ZERO = 5'h12;
  localparam logic [4:0] CLS_POS_ZERO = 5'h02;
  localparam logic [4:0] CLS_POS_DENORM = 5'h14;
  localparam logic [4:0] CLS_POS_NORM = 5'h04;
  localparam logic [4:0] CLS_POS_INF = 5'h05;

  typedef enum logic [2:0] {
    KIND_QNAN, KIND_INF, KIND_NORM, KIND_DENORM, KIND_ZERO
  } fsel_kind_t;

  typedef enum logic [1:0] {
    MT_NONE, MT_FIELD, MT_SET, MT_CLR
  } fsel_mt_kind_t;

  typedef struct packed {
    logic snan;
    logic isi;
    logic idi;
    logic zdz;
    logic imz;
    logic vc;
    logic cvi;
    logic sqrt;
    logic zx;
    logic ox;
    logic ux;
    logic xx;
  } fsel_cond_t;

  // Condition pairs that one instruction may raise together.
  localparam logic [11:0] PAIR_XX_OX = 12'h005;
  localparam logic [11:0] PAIR_XX_UX = 12'h003;
  localparam logic [11:0] PAIR_SNAN_IMZ = 12'h880;
  localparam logic [11:0] PAIR_SNAN_VC = 12'h840;
  localparam logic [11:0] PAIR_SNAN_CVI = 12'h820;

  typedef struct packed {
    logic valid;
    fsel_cond_t cond;
    logic sign;
    fsel_kind_t kind;
    logic upd_class;
    logic fr;
    logic fi;
  } fsel_op_t;

  typedef struct packed {
    fsel_mt_kind_t kind;
    logic [7:0] field_mask;
    logic [31:0] data;
    logic [4:0] bit_num;
  } fsel_mt_t;

  typedef struct packed {
    logic valid;
    logic suppress;
    logic write_result;
    logic default_result;
    logic [4:0] trap_value;
    logic flush_zero;
    logic illegal_combo;
  } fsel_resp_t;

endpackage : fsel_pkg

//--- rtl/fsel_status_unit.sv
// Floating-point status and control register with exception detection,
// summary bits, suppress/deliver decision and program exception request.
// Assumes datapath and core logic run on mclk; inputs need no sync.
`timescale 1ns/1ps

// Functional notes
// - Non-IEEE mode flushes denormal results to signed zero.
// - Rounding field selects nearest, zero, plus, minus.
// - Negative and NaN result class encodings.
// - Positive result class encodings, same bit order.
// - Each condition and invalid category has sticky bit.
// - Invalid summary is OR of invalid categories.
// - Zero divide, overflow, underflow, inexact recorded separately.
// - Detection ignores enables and machine state.
// - No governing enable set means default result.
// - Summary set on zero-to-one change or explicit set.
// - Enabled summary set when enabled condition bit set.
// - Completion with summary and mode bits requests exception.
// - Register results independent of machine-state mode bits.
// - Inexact pairs only with overflow or underflow.
// - NaN pairs with multiply-zero, compare, convert only.
// - Enabled invalid or zero divide suppresses destination write.
// - Other conditions still write a destination result.
// - Enable set selects trap value, clear selects default.
// - Enables at bits 24 to 28 in order.
// - Mode bits both clear never raise program exception.
module fsel_status_unit (
  input wire logic mclk,
  input wire logic resetn,
  input wire fsel_pkg::fsel_op_t op,
  input wire fsel_pkg::fsel_mt_t mt,
  input wire logic ni_impl_ok,
  input wire logic fp_exc_mode_hi,
  input wire logic fp_exc_mode_lo,
  output logic [31:0] fp_status_control,
  output logic [1:0] round_select,
  output logic non_ieee_mode,
  output fsel_pkg::fsel_resp_t resp,
  output logic program_exception
);

  logic [31:0] stat_r;
  logic [31:0] stat_nxt;
  logic [31:0] wmask;
  logic [31:0] after_mt;
  logic [31:0] set_vec;
  logic [31:0] new_exc;
  logic [4:0] class_code;
  logic [4:0] enables;
  logic [4:0] raised;
  logic [11:0] cond_bits;
  logic flush;
  logic inv_raised;
  logic mt_fx;
  logic combo_ok;
  fsel_pkg::fsel_resp_t resp_r;
  logic prog_exc_r;

  assign fp_status_control = stat_r;
  assign round_select = stat_r[fsel_pkg::P_RND_HI:fsel_pkg::P_RND_LO];
  assign non_ieee_mode = stat_r[fsel_pkg::P_NI];
  assign resp = resp_r;
  assign program_exception = prog_exc_r;

  // Enables in the order invalid, overflow, underflow, zero divide, inexact.
  assign enables = {stat_r[fsel_pkg::P_VE], stat_r[fsel_pkg::P_OE],
                    stat_r[fsel_pkg::P_UE], stat_r[fsel_pkg::P_ZE],
                    stat_r[fsel_pkg::P_XE]};
  assign cond_bits = op.cond;

  // Raised conditions come from the operation only.
  assign inv_raised = op.cond.snan | op.cond.isi | op.cond.idi |
                      op.cond.zdz | op.cond.imz | op.cond.vc |
                      op.cond.cvi | op.cond.sqrt;
  assign raised = {inv_raised, op.cond.ox, op.cond.ux, op.cond.zx,
                   op.cond.xx};

  assign flush = stat_r[fsel_pkg::P_NI] & ni_impl_ok &
                 (op.kind == fsel_pkg::KIND_DENORM);

  // Result class encoding; a flushed denormal is reported as zero.
  always_comb begin
    case (op.kind)
      fsel_pkg::KIND_QNAN: begin
        class_code = fsel_pkg::CLS_QNAN;
      end
      fsel_pkg::KIND_INF: begin
        class_code = op.sign ? fsel_pkg::CLS_NEG_INF
                             : fsel_pkg::CLS_POS_INF;
      end
      fsel_pkg::KIND_NORM: begin
        class_code = op.sign ? fsel_pkg::CLS_NEG_NORM
                             : fsel_pkg::CLS_POS_NORM;
      end
      fsel_pkg::KIND_DENORM: begin
        if (flush) begin
          class_code = op.sign ? fsel_pkg::CLS_NEG_ZERO
                               : fsel_pkg::CLS_POS_ZERO;
        end else begin
          class_code = op.sign ? fsel_pkg::CLS_NEG_DENORM
                               : fsel_pkg::CLS_POS_DENORM;
        end
      end
      fsel_pkg::KIND_ZERO: begin
        class_code = op.sign ? fsel_pkg::CLS_NEG_ZERO
                             : fsel_pkg::CLS_POS_ZERO;
      end
      default: begin
        class_code = fsel_pkg::CLS_QNAN;
      end
    endcase
  end

  // Only a lone condition or one of the allowed pairs is legal.
  always_comb begin
    combo_ok = ($countones(cond_bits) <= 1) ||
               (cond_bits == fsel_pkg::PAIR_XX_OX) ||
               (cond_bits == fsel_pkg::PAIR_XX_UX);
    if ((cond_bits == fsel_pkg::PAIR_SNAN_IMZ) ||
        (cond_bits == fsel_pkg::PAIR_SNAN_VC) ||
        (cond_bits == fsel_pkg::PAIR_SNAN_CVI)) begin
      combo_ok = 1'b1;
    end
  end

  // Each raised condition lands in its own sticky bit.
  always_comb begin
    set_vec = '0;
    if (op.valid) begin
      set_vec[fsel_pkg::P_SNAN] = op.cond.snan;
      set_vec[fsel_pkg::P_ISI] = op.cond.isi;
      set_vec[fsel_pkg::P_IDI] = op.cond.idi;
      set_vec[fsel_pkg::P_ZDZ] = op.cond.zdz;
      set_vec[fsel_pkg::P_IMZ] = op.cond.imz;
      set_vec[fsel_pkg::P_VC] = op.cond.vc;
      set_vec[fsel_pkg::P_CVI] = op.cond.cvi;
      set_vec[fsel_pkg::P_SQRT] = op.cond.sqrt;
      set_vec[fsel_pkg::P_ZX] = op.cond.zx;
      set_vec[fsel_pkg::P_OX] = op.cond.ox;
      set_vec[fsel_pkg::P_UX] = op.cond.ux;
      set_vec[fsel_pkg::P_XX] = op.cond.xx;
    end
  end

  // Status moves: field moves write whole nibbles, bit moves one bit.
  // The two summaries are derived and never stored from a move.
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      wmask[i] = mt.field_mask[i / 4];
    end
    wmask[fsel_pkg::P_FEX] = 1'b0;
    wmask[fsel_pkg::P_VX] = 1'b0;
    after_mt = stat_r;
    mt_fx = 1'b0;
    case (mt.kind)
      fsel_pkg::MT_FIELD: begin
        after_mt = (stat_r & ~wmask) | (mt.data & wmask);
      end
      fsel_pkg::MT_SET: begin
        after_mt[5'(fsel_pkg::TOP) - mt.bit_num] = 1'b1;
        mt_fx = fsel_pkg::EXC_MASK[5'(fsel_pkg::TOP) - mt.bit_num] &
                ~stat_r[5'(fsel_pkg::TOP) - mt.bit_num];
      end
      fsel_pkg::MT_CLR: begin
        after_mt[5'(fsel_pkg::TOP) - mt.bit_num] = 1'b0;
      end
      default: begin
        after_mt = stat_r;
      end
    endcase
  end

  // An operation's sets are merged after the move, so set beats clear.
  always_comb begin
    new_exc = set_vec & ~stat_r & fsel_pkg::EXC_MASK;
    stat_nxt = after_mt | set_vec;
    if ((new_exc != '0) || mt_fx) begin
      stat_nxt[fsel_pkg::P_FX] = 1'b1;
    end
    if (op.valid && op.upd_class) begin
      stat_nxt[fsel_pkg::P_CLASS_HI:fsel_pkg::P_CLASS_LO] = class_code;
      stat_nxt[fsel_pkg::P_FR] = op.fr;
      stat_nxt[fsel_pkg::P_FI] = op.fi;
    end
    stat_nxt[fsel_pkg::P_RSVD] = 1'b0;
    stat_nxt[fsel_pkg::P_VX] =
      |(stat_nxt & fsel_pkg::INV_MASK);
    stat_nxt[fsel_pkg::P_FEX] =
      (stat_nxt[fsel_pkg::P_VX] & stat_nxt[fsel_pkg::P_VE]) |
      (stat_nxt[fsel_pkg::P_OX] & stat_nxt[fsel_pkg::P_OE]) |
      (stat_nxt[fsel_pkg::P_UX] & stat_nxt[fsel_pkg::P_UE]) |
      (stat_nxt[fsel_pkg::P_ZX] & stat_nxt[fsel_pkg::P_ZE]) |
      (stat_nxt[fsel_pkg::P_XX] & stat_nxt[fsel_pkg::P_XE]);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stat_r <= fsel_pkg::STAT_RESET;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Completion answer to the datapath, one cycle after the operation.
  // The mode bits are not consulted here.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      resp_r <= '0;
    end else begin
      resp_r.valid <= op.valid;
      resp_r.suppress <= op.valid &
        ((inv_raised & enables[4]) | (op.cond.zx & enables[1]));
      resp_r.write_result <= op.valid &
        ~((inv_raised & enables[4]) | (op.cond.zx & enables[1]));
      resp_r.default_result <= op.valid & (raised != '0) &
        ((raised & enables) == '0);
      resp_r.trap_value <= op.valid ? (raised & enables) : '0;
      resp_r.flush_zero <= op.valid & flush;
      resp_r.illegal_combo <= op.valid & ~combo_ok;
    end
  end

  // Program exception request after an instruction that completes here with FX set and a mode bit on.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prog_exc_r <= 1'b0;
    end else begin
      prog_exc_r <= (op.valid || (mt.kind != fsel_pkg::MT_NONE)) &&
                    stat_nxt[fsel_pkg::P_FX] &&
                    (fp_exc_mode_hi || fp_exc_mode_lo);
    end
  end

endmodule : fsel_status_unit

//--- verif/fsel_status_properties.sv
// Concurrent checks on the ports of the floating-point status unit.
// Assumes one clock, mclk, and the active-low asynchronous reset resetn.
`timescale 1ns/1ps
module fsel_status_properties (
  input wire logic mclk,
  input wire logic resetn,
  input wire fsel_pkg::fsel_op_t op,
  input wire fsel_pkg::fsel_mt_t mt,
  input wire logic ni_impl_ok,
  input wire logic fp_exc_mode_hi,
  input wire logic fp_exc_mode_lo,
  input wire logic [31:0] fp_status_control,
  input wire logic [1:0] round_select,
  input wire logic non_ieee_mode,
  input wire fsel_pkg::fsel_resp_t resp,
  input wire logic program_exception
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [31:0] s;
  logic inv;
  logic hit;
  logic trap;
  logic multi;
  logic pair_ok;
  assign s = fp_status_control;
  assign multi = $countones(op.cond) > 1;
  assign pair_ok = (op.cond == fsel_pkg::PAIR_XX_OX) ||
                   (op.cond == fsel_pkg::PAIR_XX_UX) ||
                   (op.cond == fsel_pkg::PAIR_SNAN_IMZ) ||
                   (op.cond == fsel_pkg::PAIR_SNAN_VC) ||
                   (op.cond == fsel_pkg::PAIR_SNAN_CVI);
  assign inv = |op.cond[11:4];
  assign hit = |({inv, op.cond[3:0]} & {s[7], s[4], s[6], s[5], s[3]});
  assign trap = (inv & s[7]) | (op.cond.zx & s[4]);
  sequence s_fx_done;
    op.valid && (fp_exc_mode_hi || fp_exc_mode_lo) ##1 s[31];
  endsequence
  property p_resp;
    op.valid |=> resp.valid &&
      (resp.default_result == ($past(|op.cond) && !$past(hit)));
  endproperty
  a_resp: assert property (p_resp) else $error("bad default flag");
  property p_supp;
    op.valid && trap |=> resp.suppress && !resp.write_result;
  endproperty
  a_supp: assert property (p_supp) else $error("not suppressed");
  property p_deliv;
    op.valid && !trap |=> resp.write_result && !resp.suppress;
  endproperty
  a_deliv: assert property (p_deliv) else $error("no result");
  property p_vx;
    s[29] == |(s & fsel_pkg::INV_MASK);
  endproperty
  a_vx: assert property (p_vx) else $error("invalid summary wrong");
  property p_fex;
    s[30] == |(s[29:25] & s[7:3]);
  endproperty
  a_fex: assert property (p_fex) else $error("enabled summary wrong");
  property p_zx;
    op.valid && op.cond.zx && !s[26] |=> s[26] && s[31];
  endproperty
  a_zx: assert property (p_zx) else $error("zero divide lost");
  property p_sticky;
    mt.kind == fsel_pkg::MT_NONE |=>
      (s & $past(s & fsel_pkg::EXC_MASK)) == $past(s & fsel_pkg::EXC_MASK);
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky bit lost");
  property p_pe;
    s_fx_done |-> program_exception;
  endproperty
  a_pe: assert property (p_pe) else $error("no program exception");
  property p_quiet;
    program_exception |-> $past(fp_exc_mode_hi) || $past(fp_exc_mode_lo);
  endproperty
  a_quiet: assert property (p_quiet) else $error("exception in ignore mode");
  property p_flush;
    op.valid && op.upd_class && op.kind == fsel_pkg::KIND_DENORM &&
      non_ieee_mode && ni_impl_ok |=> resp.flush_zero && s[15:12] == 4'h2;
  endproperty
  a_flush: assert property (p_flush) else $error("denormal not flushed");
  property p_combo;
    op.valid |=> resp.illegal_combo == $past(multi && !pair_ok);
  endproperty
  a_combo: assert property (p_combo) else $error("bad combo");
endmodule : fsel_status_properties

bind fsel_status_unit fsel_status_properties u_props (.mclk(mclk),
  .resetn(resetn), .op(op), .mt(mt), .ni_impl_ok(ni_impl_ok),
  .fp_exc_mode_hi(fp_exc_mode_hi), .fp_exc_mode_lo(fp_exc_mode_lo),
  .fp_status_control(fp_status_control), .round_select(round_select),
  .non_ieee_mode(non_ieee_mode), .resp(resp),
  .program_exception(program_exception));

//--- verif/fsel_fp_source.sv
// Behavioural model of the floating-point datapath and core side.
// Assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/1ps
module fsel_fp_source (
  input wire logic mclk,
  output fsel_pkg::fsel_op_t op,
  output fsel_pkg::fsel_mt_t mt
);
  initial begin
    op = '0;
    mt = '0;
  end
  // One completion report; the condition vector c is sent as given, legal or not.
  task automatic send_op(input logic [11:0] c, input logic sg,
      input fsel_pkg::fsel_kind_t k);
    @(posedge mclk);
    op <= {1'h1, c, sg, k, 3'h4};
    @(posedge mclk);
    op <= '0;
    #1;
  endtask : send_op
  task automatic send_mt(input fsel_pkg::fsel_mt_kind_t k,
      input logic [7:0] m, input logic [31:0] d, input logic [4:0] b);
    @(posedge mclk);
    mt <= {k, m, d, b};
    @(posedge mclk);
    mt <= '0;
    #1;
  endtask : send_mt
endmodule : fsel_fp_source

//--- verif/testbench.sv
// Self-checking bench for the floating-point status unit.
// Assumes the datapath model drives op and mt through its tasks.
`timescale 1ns/1ps
module testbench;
  logic mclk, resetn, ni_ok, mode_hi, mode_lo, ni, pe;
  fsel_pkg::fsel_op_t op;
  fsel_pkg::fsel_mt_t mt;
  fsel_pkg::fsel_resp_t resp;
  logic [31:0] st;
  logic [1:0] rs;
  int failures, n_tests;
  fsel_fp_source u_src (.mclk(mclk), .op(op), .mt(mt));
  fsel_status_unit u_dut (.mclk(mclk), .resetn(resetn), .op(op), .mt(mt),
    .ni_impl_ok(ni_ok), .fp_exc_mode_hi(mode_hi), .fp_exc_mode_lo(mode_lo),
    .fp_status_control(st), .round_select(rs), .non_ieee_mode(ni),
    .resp(resp), .program_exception(pe));
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic clr();
    u_src.send_mt(fsel_pkg::MT_FIELD, 8'hFF, 32'h0, 5'h0);
  endtask : clr
  task automatic t_cond();
    int pos[12] = '{24, 23, 22, 21, 20, 19, 8, 9, 26, 28, 27, 25};
    logic [31:0] vmask;
    logic [31:0] exp_v;
    vmask = fsel_pkg::EXC_MASK | (32'h1 << fsel_pkg::P_VX);
    for (int i = 0; i < 12; i++) begin
      clr();
      u_src.send_op(12'h800 >> i, 1'h0, fsel_pkg::KIND_NORM);
      exp_v = (32'h1 << pos[i]) | (i < 8 ? 32'h2000_0000 : 32'h0);
      chk(st & vmask, exp_v);
      chk(32'({st[31], resp.default_result, pe}), 32'h6);
    end
    u_src.send_op(12'h004, 1'h0, fsel_pkg::KIND_NORM);
    chk(st & vmask, 32'h1200_0000);
    $display("test conditions done");
  endtask : t_cond
  task automatic t_enable();
    clr();
    u_src.send_mt(fsel_pkg::MT_FIELD, 8'h03, 32'h90, 5'h0);
    @(posedge mclk);
    mode_hi <= 1'h1;
    u_src.send_op(12'h008, 1'h0, fsel_pkg::KIND_NORM);
    chk(32'({resp.suppress, resp.write_result, resp.trap_value}), 32'h42);
    chk(32'({st[31:30], st[26], pe}), 32'hF);
    u_src.send_op(12'h004, 1'h0, fsel_pkg::KIND_NORM);
    chk(32'({resp.suppress, resp.write_result, resp.default_result}), 32'h3);
    u_src.send_mt(fsel_pkg::MT_FIELD, 8'h02, 32'hD0, 5'h0);
    u_src.send_op(12'h004, 1'h0, fsel_pkg::KIND_NORM);
    chk(32'({resp.suppress, resp.write_result, resp.default_result,
      resp.trap_value}), 32'h48);
    @(posedge mclk);
    mode_hi <= 1'h0;
    clr();
    u_src.send_mt(fsel_pkg::MT_SET, 8'h0, 32'h0, 5'h5);
    chk(32'({st[31], st[26], pe}), 32'h6);
    @(posedge mclk);
    mode_lo <= 1'h1;
    u_src.send_op(12'h0, 1'h0, fsel_pkg::KIND_NORM);
    chk(32'(pe), 32'h1);
    @(posedge mclk);
    mode_lo <= 1'h0;
    $display("test enables done");
  endtask : t_enable
  task automatic t_class();
    int kd[9] = '{0, 1, 2, 3, 4, 4, 3, 2, 1};
    logic [4:0] cl[9] = '{5'h11, 5'h09, 5'h08, 5'h18, 5'h12, 5'h02, 5'h14,
      5'h04, 5'h05};
    for (int i = 0; i < 9; i++) begin
      u_src.send_op(12'h0, 1'(i > 0 && i < 5), fsel_pkg::fsel_kind_t'(kd[i]));
      chk(32'(st[16:12]), 32'(cl[i]));
    end
    u_src.send_mt(fsel_pkg::MT_FIELD, 8'h01, 32'h4, 5'h0);
    u_src.send_op(12'h0, 1'h1, fsel_pkg::KIND_DENORM);
    chk(32'({resp.flush_zero, st[16:12]}), 32'h32);
    @(posedge mclk);
    ni_ok <= 1'h0;
    u_src.send_op(12'h0, 1'h1, fsel_pkg::KIND_DENORM);
    chk(32'({resp.flush_zero, st[16:12]}), 32'h18);
    $display("test classes done");
  endtask : t_class
  task automatic t_round();
    for (int i = 0; i < 4; i++) begin
      u_src.send_mt(fsel_pkg::MT_FIELD, 8'h01, 32'h4 | i, 5'h0);
      chk(32'({ni, rs}), 32'h4 | i);
    end
    $display("test rounding done");
  endtask : t_round
  task automatic t_combo();
    u_src.send_op(12'h005, 1'h0, fsel_pkg::KIND_NORM);
    chk(32'(resp.illegal_combo), 32'h0);
    u_src.send_op(12'h880, 1'h0, fsel_pkg::KIND_NORM);
    chk(32'(resp.illegal_combo), 32'h0);
    u_src.send_op(12'h00A, 1'h0, fsel_pkg::KIND_NORM);
    chk(32'(resp.illegal_combo), 32'h1);
    u_src.send_op(12'h900, 1'h0, fsel_pkg::KIND_NORM);
    chk(32'(resp.illegal_combo), 32'h1);
    $display("test combinations done");
  endtask : t_combo
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    test_done();
  end
  initial begin
    resetn = 1'h0;
    ni_ok = 1'h0;
    mode_hi = 1'h0;
    mode_lo = 1'h0;
    failures = 0;
    n_tests = 0;
    repeat (5) @(posedge mclk);
    chk(st, 32'h0);
    resetn <= 1'h1;
    ni_ok <= 1'h1;
    t_cond();
    t_enable();
    t_class();
    t_round();
    t_combo();
    test_done();
  end
endmodule : testbench
